// ### hw/crc4_serial.sv
// Serial CRC-4 engine, generator x^4 + x + 1, msb of remainder is the first check bit
`timescale 1ns/10ps
module crc4_serial
  import e1_ts0_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic restart,
  input wire logic data_bit,
  output logic [3:0] crc
);

  function automatic logic [3:0] crc_step(input logic [3:0] r, input logic d);
    logic fb;
    fb = d ^ r[3];
    crc_step = {r[2], r[1], r[0] ^ fb, fb};
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc <= CRC_INIT;
    end else if (en) begin
      crc <= crc_step(restart ? CRC_INIT : crc, data_bit);
    end
  end

endmodule // crc4_serial

// ### hw/e1_crc_multiframe_ts0_formatter.sv
// E1 check multiframe timeslot 0 formatter: transmit insertion and receive multiframe location
`timescale 1ns/10ps
// Contract
// - Both streams are grouped into multiframes of sixteen frames that open with an alignment-word frame.
// - Each multiframe splits into two halves of eight frames, alternating alignment-word and other frames.
// - Bit 0 of the alignment-word frames of a half carries the four check bits, first to fourth in order.
// - A 4-bit cyclic check is computed over each half and sent in the check positions of the next half.
// - Bit 0 of the other frames carries 0,0,1,0,1,1 over the first six and two error bits in the last two.
// - The error bits report halves that the local receiver found with mismatching check bits.
// - Bit 1 of every other frame is sent as a constant 1 and the far receiver uses it for alignment search.
// - The remote alarm bit is 0 in normal operation and changes only to signal an alarm.
// - The receiver takes bit 0 of each other frame and uses those bits to find the multiframe boundary.
module e1_crc_multiframe_ts0_formatter
  import e1_ts0_pkg::*;
#(
  parameter int CLKS_PER_BIT = 1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_payload,
  input wire logic remote_alarm,
  input wire logic [4:0] national_spare,
  output logic tx_line,
  output logic tx_bit_valid,
  output logic tx_mf_start,
  input wire logic rx_line,
  input wire logic rx_frame_sync,
  output logic rx_mf_locked,
  output logic rx_mf_start,
  output logic rx_crc_error,
  output logic [3:0] rx_frame_number
);

  ////////////////////////////////////////////////////////////////////////////
  // Bit rate enable
  logic [15:0] div_cnt;
  logic bit_tick;

  assign bit_tick = (div_cnt == 16'(CLKS_PER_BIT - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 16'h0000;
    end else if (bit_tick) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit position
  logic [7:0] tx_bit;
  logic [3:0] tx_frame;
  logic [2:0] tx_pos;
  logic tx_in_ts0;
  logic tx_align_frame;
  logic tx_half_start;

  assign tx_pos = tx_bit[2:0];
  assign tx_in_ts0 = (tx_bit[7:3] == 5'h00);
  assign tx_align_frame = ~tx_frame[0];
  assign tx_half_start = (tx_bit == 8'h00) && (tx_frame[2:0] == 3'h0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_bit <= 8'h00;
      tx_frame <= 4'h0;
    end else if (bit_tick) begin
      tx_bit <= tx_bit + 8'h01;
      if (tx_bit == LAST_BIT) begin
        tx_frame <= tx_frame + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit timeslot 0 content
  logic [3:0] tx_crc;
  logic [3:0] tx_cbits;
  logic [3:0] cbits_now;
  logic [1:0] e_pend;
  logic [2:0] nfas_slot;
  logic ts0_bit;
  logic next_line;
  logic crc_in;

  assign cbits_now = tx_half_start ? tx_crc : tx_cbits;
  assign nfas_slot = tx_frame[3:1];

  always_comb begin
    ts0_bit = 1'b0;
    if (tx_align_frame) begin
      if (tx_pos == POS_SI) begin
        ts0_bit = cbits_now[2'(3 - tx_frame[2:1])];
      end else begin
        ts0_bit = ALIGN_WORD[3'(TS0_LAST_POS - tx_pos)];
      end
    end else begin
      case (tx_pos)
        POS_SI: begin
          if (nfas_slot < MF_PATTERN_LEN) begin
            ts0_bit = MF_PATTERN[3'(MF_PATTERN_LEN - 3'h1 - nfas_slot)];
          end else begin
            ts0_bit = ~e_pend[nfas_slot == E_LAST_SLOT];
          end
        end
        POS_FIXED: ts0_bit = FIXED_ONE;
        POS_ALARM: ts0_bit = remote_alarm ? ~ALARM_IDLE : ALARM_IDLE;
        default: ts0_bit = national_spare[3'(tx_pos - POS_SPARE)];
      endcase
    end
  end

  // Bit 0 of the octet leaves first
  assign next_line = tx_in_ts0 ? ts0_bit : tx_payload;
  // Check positions count as zero in the sum
  assign crc_in = (tx_in_ts0 && tx_align_frame && tx_pos == POS_SI) ? 1'b0 : next_line;

  crc4_serial u_tx_crc (
    .clk(clk),
    .rst_n(rst_n),
    .en(bit_tick),
    .restart(tx_half_start),
    .data_bit(crc_in),
    .crc(tx_crc)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_cbits <= CRC_INIT;
    end else if (bit_tick && tx_half_start) begin
      tx_cbits <= tx_crc;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_line <= 1'b0;
      tx_bit_valid <= 1'b0;
      tx_mf_start <= 1'b0;
    end else begin
      tx_bit_valid <= bit_tick;
      tx_mf_start <= bit_tick && tx_half_start && (tx_frame == 4'h0);
      if (bit_tick) begin
        tx_line <= next_line;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive position and multiframe search
  logic [7:0] rx_cnt;
  logic [7:0] rx_pos;
  logic [3:0] rx_frame;
  logic [3:0] rx_cur_frame;
  logic rx_b0;
  logic [5:0] rx_hist;
  logic [5:0] next_hist;
  logic rx_nfas;
  logic rx_match;

  assign rx_pos = rx_frame_sync ? 8'h00 : rx_cnt;
  assign rx_cur_frame = (rx_pos == 8'h00) ? rx_frame + 4'h1 : rx_frame;
  assign rx_nfas = (rx_pos == 8'(POS_FIXED)) && rx_line;
  assign next_hist = {rx_hist[4:0], rx_b0};
  assign rx_match = (next_hist == MF_PATTERN);
  assign rx_frame_number = rx_frame;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt <= 8'h00;
      rx_b0 <= 1'b0;
      rx_hist <= 6'h00;
    end else if (bit_tick) begin
      rx_cnt <= rx_pos + 8'h01;
      if (rx_pos == 8'(POS_SI)) begin
        rx_b0 <= rx_line;
      end
      if (rx_nfas) begin
        rx_hist <= next_hist;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_frame <= 4'h0;
      rx_mf_locked <= 1'b0;
    end else if (bit_tick) begin
      if (rx_nfas && rx_match) begin
        rx_frame <= MF_MATCH_FRAME;
        rx_mf_locked <= 1'b1;
      end else begin
        if (rx_nfas && rx_frame == MF_MATCH_FRAME) begin
          rx_mf_locked <= 1'b0;
        end
        if (rx_pos == 8'h00) begin
          rx_frame <= rx_frame + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive check
  logic rx_half_start;
  logic rx_cpos;
  logic [3:0] rx_crc;
  logic [3:0] rx_crc_prev;
  logic [3:0] rx_cbits;
  logic rx_prev_valid;
  logic rx_half_seen;
  logic rx_err_now;

  assign rx_half_start = (rx_pos == 8'h00) && (rx_cur_frame[2:0] == 3'h0);
  assign rx_cpos = (rx_pos == 8'h00) && ~rx_cur_frame[0];
  assign rx_err_now = bit_tick && rx_half_start && rx_mf_locked && rx_prev_valid && (rx_cbits != rx_crc_prev);

  crc4_serial u_rx_crc (
    .clk(clk),
    .rst_n(rst_n),
    .en(bit_tick),
    .restart(rx_half_start),
    .data_bit(rx_cpos ? 1'b0 : rx_line),
    .crc(rx_crc)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cbits <= CRC_INIT;
      rx_crc_prev <= CRC_INIT;
      rx_prev_valid <= 1'b0;
      rx_half_seen <= 1'b0;
    end else if (bit_tick) begin
      if (rx_cpos) begin
        rx_cbits[2'(3 - rx_cur_frame[2:1])] <= rx_line;
      end
      // Compare only halves seen whole while locked
      if (!rx_mf_locked) begin
        rx_prev_valid <= 1'b0;
        rx_half_seen <= 1'b0;
      end else if (rx_half_start) begin
        rx_crc_prev <= rx_crc;
        rx_half_seen <= 1'b1;
        rx_prev_valid <= rx_half_seen;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_crc_error <= 1'b0;
      rx_mf_start <= 1'b0;
    end else begin
      rx_crc_error <= rx_err_now;
      rx_mf_start <= bit_tick && rx_mf_locked && (rx_pos == 8'h00) && (rx_cur_frame == 4'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error bits owed to the far end, set wins over clear
  logic e_send0;
  logic e_send1;

  assign e_send0 = bit_tick && tx_in_ts0 && !tx_align_frame && tx_pos == POS_SI && nfas_slot == E_FIRST_SLOT;
  assign e_send1 = bit_tick && tx_in_ts0 && !tx_align_frame && tx_pos == POS_SI && nfas_slot == E_LAST_SLOT;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      e_pend <= 2'b00;
    end else begin
      if (rx_err_now && rx_cur_frame[3]) begin
        e_pend[0] <= 1'b1;
      end else if (e_send0) begin
        e_pend[0] <= 1'b0;
      end
      if (rx_err_now && !rx_cur_frame[3]) begin
        e_pend[1] <= 1'b1;
      end else if (e_send1) begin
        e_pend[1] <= 1'b0;
      end
    end
  end

endmodule // e1_crc_multiframe_ts0_formatter

// ### pkg/e1_ts0_pkg.sv
// Constants for the E1 check multiframe timeslot 0 formatter
package e1_ts0_pkg;
  localparam int FRAME_BITS = 256;
  localparam logic [7:0] LAST_BIT = 8'hff;
  localparam logic [3:0] MF_FRAMES_LAST = 4'hf;
  localparam logic [2:0] TS0_LAST_POS = 3'h7;
  localparam logic [2:0] POS_SI = 3'h0;
  localparam logic [2:0] POS_FIXED = 3'h1;
  localparam logic [2:0] POS_ALARM = 3'h2;
  localparam logic [2:0] POS_SPARE = 3'h3;
  // Alignment word, bit 1 in the top position
  localparam logic [6:0] ALIGN_WORD = 7'h1b;
  // Multiframe alignment sequence, first bit in the top position
  localparam logic [5:0] MF_PATTERN = 6'h0b;
  localparam logic [2:0] MF_PATTERN_LEN = 3'h6;
  localparam logic [2:0] E_FIRST_SLOT = 3'h6;
  localparam logic [2:0] E_LAST_SLOT = 3'h7;
  // Frame whose bit 0 ends the alignment sequence
  localparam logic [3:0] MF_MATCH_FRAME = 4'hb;
  localparam logic [3:0] CRC_INIT = 4'h0;
  localparam logic FIXED_ONE = 1'b1;
  localparam logic ALARM_IDLE = 1'b0;
endpackage

// ### sim/e1_crc_multiframe_ts0_formatter_tb.sv
// Self-checking testbench for the timeslot 0 formatter
`timescale 1ns/10ps
module e1_crc_multiframe_ts0_formatter_tb;
  import e1_ts0_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tx_payload = 1'b0;
  logic remote_alarm = 1'b0;
  logic [4:0] national_spare = 5'h00;
  logic corrupt = 1'b0;
  logic tx_line, tx_bit_valid, tx_mf_start, rx_line, rx_frame_sync;
  logic rx_mf_locked, rx_mf_start, rx_crc_error, fixed_bad;
  logic [3:0] rx_frame_number;
  logic [5:0] pcnt = 6'h00;
  logic [4095:0] mf;
  int error_cnt = 0;
  int num_checks = 0;
  int errs = 0;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    pcnt <= pcnt + 6'h01;
    tx_payload <= pcnt[1] ^ pcnt[4];
    if (rx_crc_error === 1'b1) errs++;
  end
  e1_crc_multiframe_ts0_formatter #(.CLKS_PER_BIT(1)) uut (.clk(clk), .rst_n(rst_n), .tx_payload(tx_payload),
    .remote_alarm(remote_alarm), .national_spare(national_spare), .tx_line(tx_line), .tx_bit_valid(tx_bit_valid),
    .tx_mf_start(tx_mf_start), .rx_line(rx_line), .rx_frame_sync(rx_frame_sync), .rx_mf_locked(rx_mf_locked),
    .rx_mf_start(rx_mf_start), .rx_crc_error(rx_crc_error), .rx_frame_number(rx_frame_number));
  e1_remote_framer far (.clk(clk), .rst_n(rst_n), .tx_line(tx_line), .tx_bit_valid(tx_bit_valid),
    .tx_mf_start(tx_mf_start), .corrupt(corrupt), .rx_line(rx_line), .rx_frame_sync(rx_frame_sync),
    .fixed_bad(fixed_bad));
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic grab;
    int i;
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (tx_mf_start !== 1'b1 && i < 5000);
    for (i = 0; i < 4096; i++) begin
      mf[i] = tx_line;
      @(posedge clk);
      #1;
    end
  endtask
  task automatic check_mf(input logic al, input logic [4:0] sp, input logic [1:0] e);
    logic [3:0] c;
    logic [7:0] o;
    logic [7:0] seq;
    logic fb;
    c = 4'h0;
    seq = {e, 6'h34};
    for (int i = 0; i < 2048; i++) begin
      fb = c[3] ^ (i % 512 != 0 && mf[i]);
      c = {c[2:0], 1'b0} ^ {2'b00, fb, fb};
    end
    chk({12'h000, c}, {12'h000, mf[2048], mf[2560], mf[3072], mf[3584]});
    for (int f = 0; f < 16; f++) begin
      o = mf[f*256 +: 8];
      if (f % 2 == 0) chk({8'h00, o[7:1], 1'b0}, 16'h00d8);
      else chk({8'h00, o}, {8'h00, sp, al, 1'b1, seq[f/2]});
    end
  endtask
  task automatic wait_start(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (rx_mf_start !== 1'b1 && n < 9000);
  endtask
  task automatic t_format;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      remote_alarm <= k[0];
      national_spare <= k[0] ? 5'h0a : 5'h15;
      grab;
      check_mf(k[0], k[0] ? 5'h0a : 5'h15, 2'b11);
    end
    $display("format test done");
  endtask
  task automatic t_lock;
    int n;
    wait_start(n);
    chk({15'h0000, rx_mf_locked}, 16'h0001);
    chk({12'h000, rx_frame_number}, 16'h0000);
    wait_start(n);
    chk(16'(n), 16'h1000);
    chk(16'(errs), 16'h0000);
    $display("lock test done");
  endtask
  task automatic t_crc;
    int n;
    n = errs;
    grab;
    @(posedge clk);
    corrupt <= 1'b1;
    repeat (200) @(posedge clk);
    corrupt <= 1'b0;
    grab;
    check_mf(1'b1, 5'h0a, 2'b01);
    chk(16'(errs - n), 16'h0001);
    chk({15'h0000, fixed_bad}, 16'h0000);
    $display("check error test done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_format;
    t_lock;
    t_crc;
    conclude;
  end
  // About 40k cycles expected, cut off at 100k
  initial begin
    #2000000;
    error_cnt++;
    conclude;
  end
endmodule // e1_crc_multiframe_ts0_formatter_tb

// ### sim/e1_remote_framer.sv
// Far-end framer model: line loopback with payload corruption
`timescale 1ns/10ps
module e1_remote_framer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_line,
  input wire logic tx_bit_valid,
  input wire logic tx_mf_start,
  input wire logic corrupt,
  output logic rx_line,
  output logic rx_frame_sync,
  output logic fixed_bad
);
  logic [11:0] pos;
  wire [11:0] cur = tx_mf_start ? 12'h000 : pos;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos <= 12'h000;
      rx_line <= 1'b0;
      rx_frame_sync <= 1'b0;
      fixed_bad <= 1'b0;
    end else if (tx_bit_valid) begin
      pos <= cur + 12'h001;
      rx_line <= tx_line ^ (corrupt && cur[7:0] == 8'h64);
      rx_frame_sync <= cur[7:0] == 8'h00;
      if (cur[8] && cur[7:0] == 8'h01 && !tx_line) begin
        fixed_bad <= 1'b1;
      end
    end
  end
endmodule // e1_remote_framer

// ### sim/e1_ts0_monitor.sv
// Port checker for the timeslot 0 formatter
`timescale 1ns/10ps
module e1_ts0_monitor
  import e1_ts0_pkg::*;
#(parameter int CLKS_PER_BIT = 1)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_payload,
  input wire logic remote_alarm,
  input wire logic [4:0] national_spare,
  input wire logic tx_line,
  input wire logic tx_bit_valid,
  input wire logic tx_mf_start,
  input wire logic rx_line,
  input wire logic rx_frame_sync,
  input wire logic rx_mf_locked,
  input wire logic rx_mf_start,
  input wire logic rx_crc_error,
  input wire logic [3:0] rx_frame_number
);
  logic [11:0] tc, rc;
  logic ts, rs;
  logic [5:0] in1, in2;
  wire [11:0] ti = tx_mf_start ? 12'h000 : tc;
  wire odd = ti[8];
  wire [7:0] b = ti[7:0];
  wire st = in1 == {remote_alarm, national_spare} && in2 == in1;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tc <= 12'h000;
      ts <= 1'b0;
    end else if (tx_bit_valid) begin
      tc <= ti + 12'h001;
      ts <= ts | tx_mf_start;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rc <= 12'h000;
      rs <= 1'b0;
    end else begin
      rc <= rx_mf_start ? 12'h001 : rc + 12'h001;
      rs <= rs | rx_mf_start;
    end
  end
  always_ff @(posedge clk) begin
    in1 <= {remote_alarm, national_spare};
    in2 <= in1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_tx_spacing: assert property (tx_mf_start && ts |-> tc == 12'h000)
    else $error("tx multiframe spacing wrong");
  chk_tx_pace: assert property (tx_bit_valid |=> tx_bit_valid)
    else $error("tx bit stream stalled");
  chk_fixed_one: assert property (tx_bit_valid && odd && b == 8'h01 |-> tx_line)
    else $error("fixed bit not one");
  chk_align_word: assert property (tx_bit_valid && !odd && b[7:3] == 5'h00 && b[2:0] != 3'h0
    |-> tx_line == ALIGN_WORD[3'h7 - b[2:0]]) else $error("alignment word bit wrong");
  chk_mf_pattern: assert property (tx_bit_valid && odd && b == 8'h00 && ti[11:9] < 3'h6
    |-> tx_line == MF_PATTERN[3'h5 - ti[11:9]]) else $error("multiframe pattern bit wrong");
  chk_alarm_bit: assert property (tx_bit_valid && odd && b == 8'h02 && st |-> tx_line == remote_alarm)
    else $error("alarm bit wrong");
  chk_rx_spacing: assert property (rx_mf_start && rs |-> rc == 12'h000 && rx_mf_locked)
    else $error("rx multiframe start misplaced");
  chk_err_boundary: assert property (rx_crc_error |-> rx_mf_locked && rs && rc[10:0] == 11'h000)
    else $error("check error off a half boundary");
endmodule // e1_ts0_monitor
bind e1_crc_multiframe_ts0_formatter e1_ts0_monitor #(.CLKS_PER_BIT(CLKS_PER_BIT)) mon (.clk(clk),
  .rst_n(rst_n), .tx_payload(tx_payload), .remote_alarm(remote_alarm), .national_spare(national_spare),
  .tx_line(tx_line), .tx_bit_valid(tx_bit_valid), .tx_mf_start(tx_mf_start), .rx_line(rx_line),
  .rx_frame_sync(rx_frame_sync), .rx_mf_locked(rx_mf_locked), .rx_mf_start(rx_mf_start),
  .rx_crc_error(rx_crc_error), .rx_frame_number(rx_frame_number));
